/* File: hw/acs_sequencer.sv */
// adc conversion sequencer: register file, prescaler and conversion control
module acs_sequencer (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire acs_pkg::acs_bus_type  bus,
  output logic [7:0]                 rdata,
  input  wire logic [9:0]            core_result,
  output acs_pkg::acs_core_type      core,
  output logic                       irq
);
  acs_pkg::acs_reg_type r_q;
  acs_pkg::acs_reg_type r_d;

  logic [6:0] pre_div;
  logic       adc_rise;
  logic       done;
  logic       armed;
  logic       launch;
  logic [7:0] clear_bits;

  always_comb
  begin
    case (r_q.ctrl[2:0])
      3'h0, 3'h1: pre_div = 7'h01;
      3'h2:       pre_div = 7'h02;
      3'h3:       pre_div = 7'h04;
      3'h4:       pre_div = 7'h08;
      3'h5:       pre_div = 7'h10;
      3'h6:       pre_div = 7'h20;
      default:    pre_div = 7'h40;
    endcase
  end

  always_comb
  begin
    r_d = r_q;
    adc_rise = 1'b0;
    done = 1'b0;
    armed = 1'b0;
    launch = 1'b0;
    clear_bits = 8'h00;
    // prescaler: half-period counter on ref_clk
    if (!r_q.ctrl[acs_pkg::ACS_BIT_EN])
    begin
      r_d.pre_cnt = 7'h00;
      r_d.adc_clk = 1'b0;
      r_d.edge_par = 1'b0;
    end
    // prescale change mid-count must not run the counter round to wrap
    else if (r_q.pre_cnt >= pre_div - 7'h01)
    begin
      r_d.pre_cnt = 7'h00;
      r_d.adc_clk = ~r_q.adc_clk;
      adc_rise = ~r_q.adc_clk;
    end
    else
    begin
      r_d.pre_cnt = r_q.pre_cnt + 7'h01;
    end
    if (adc_rise)
    begin
      r_d.edge_par = ~r_q.edge_par;
    end
    // reference change arms an extended conversion; a newly chosen differential input is only checked at launch
    if (r_q.mux[7:6] != r_q.last_ref)
    begin
      r_d.ext_pend = 1'b1;
    end
    case (r_q.state)
      acs_pkg::ACS_IDLE:
      begin
        // a start bit set now may use an adc edge in this very cycle
        armed = r_q.ctrl[acs_pkg::ACS_BIT_SC];
        if (r_q.ctrl[acs_pkg::ACS_BIT_SC])
        begin
          r_d.state = acs_pkg::ACS_WAIT;
        end
      end
      acs_pkg::ACS_WAIT:
      begin
        armed = 1'b1;
      end
      default:
      begin
        if (adc_rise)
        begin
          if (r_q.cyc == r_q.cyc_len - 5'h01)
          begin
            done = 1'b1;
          end
          else
          begin
            r_d.cyc = r_q.cyc + 5'h01;
          end
        end
      end
    endcase
    // hold asserted during the low half of the documented cycle
    r_d.hold = (r_q.state == acs_pkg::ACS_CONV) && r_q.adc_clk && !r_d.adc_clk
      && (r_q.cyc == ((r_q.cyc_len == acs_pkg::ACS_EXTENDED_CYCLES) ?
          acs_pkg::ACS_HOLD_EXTENDED : acs_pkg::ACS_HOLD_NORMAL));
    if (done)
    begin
      r_d.data = core_result;
      r_d.ctrl[acs_pkg::ACS_BIT_IF] = 1'b1;
      r_d.istat = 1'b1;
      if (r_q.ctrl[acs_pkg::ACS_BIT_FR])
      begin
        r_d.state = acs_pkg::ACS_WAIT;
      end
      else
      begin
        r_d.ctrl[acs_pkg::ACS_BIT_SC] = 1'b0;
        r_d.state = acs_pkg::ACS_IDLE;
      end
    end
    // free-running restarts on the completing edge, no idle adc cycle between; diff inputs wait one more adc edge for odd parity
    armed = armed || (done && r_q.ctrl[acs_pkg::ACS_BIT_FR]);
    // diff inputs start only on odd-numbered edges counted from enable
    launch = armed && adc_rise
      && (!r_q.mux[acs_pkg::ACS_BIT_DIFF] || !r_q.edge_par);
    if (launch)
    begin
      r_d.state = acs_pkg::ACS_CONV;
      r_d.act_mux = r_q.mux[2:0];
      r_d.last_ref = r_q.mux[7:6];
      r_d.last_diff = r_q.mux[acs_pkg::ACS_BIT_DIFF];
      r_d.cyc = 5'h00;
      if (r_q.ext_pend || (r_q.mux[acs_pkg::ACS_BIT_DIFF] && !r_q.last_diff)
          || r_q.mux[7:6] != r_q.last_ref)
      begin
        r_d.cyc_len = acs_pkg::ACS_EXTENDED_CYCLES;
      end
      else
      begin
        r_d.cyc_len = acs_pkg::ACS_NORMAL_CYCLES;
      end
      r_d.ext_pend = 1'b0;
    end
    // register writes; hardware set beats a software clear
    if (bus.wr)
    begin
      if (bus.addr == acs_pkg::ACS_ADDR_CTRL)
      begin
        r_d.ctrl[7] = bus.wdata[7];
        r_d.ctrl[5] = bus.wdata[5];
        r_d.ctrl[3:0] = bus.wdata[3:0];
        if (bus.wdata[acs_pkg::ACS_BIT_SC])
        begin
          r_d.ctrl[acs_pkg::ACS_BIT_SC] = 1'b1;
        end
        if (bus.wdata[acs_pkg::ACS_BIT_IF] && !done)
        begin
          r_d.ctrl[acs_pkg::ACS_BIT_IF] = 1'b0;
        end
        if (bus.wdata[acs_pkg::ACS_BIT_EN] && !r_q.ctrl[acs_pkg::ACS_BIT_EN])
        begin
          r_d.ext_pend = 1'b1;
        end
      end
      else if (bus.addr == acs_pkg::ACS_ADDR_MUX)
      begin
        r_d.mux = {bus.wdata[7:5], 2'h0, bus.wdata[2:0]};
      end
      else if (bus.addr == acs_pkg::ACS_ADDR_IMASK)
      begin
        r_d.imask = bus.wdata[0:0];
      end
      else if (bus.addr == acs_pkg::ACS_ADDR_ISTAT)
      begin
        clear_bits[0] = bus.wdata[0];
      end
    end
    if (clear_bits[0] && !done)
    begin
      r_d.istat = 1'b0;
    end
    // disable aborts and forces idle
    if (!r_d.ctrl[acs_pkg::ACS_BIT_EN])
    begin
      r_d.state = acs_pkg::ACS_IDLE;
      r_d.ctrl[acs_pkg::ACS_BIT_SC] = 1'b0;
    end
    if (bus.rd)
    begin
      if (bus.addr == acs_pkg::ACS_ADDR_CTRL)
      begin
        r_d.rdata = r_q.ctrl;
      end
      else if (bus.addr == acs_pkg::ACS_ADDR_MUX)
      begin
        r_d.rdata = {r_q.mux[7:5], 2'h0, r_q.mux[2:0]};
      end
      else if (bus.addr == acs_pkg::ACS_ADDR_DATA_L)
      begin
        r_d.rdata = r_q.data[7:0];
      end
      else if (bus.addr == acs_pkg::ACS_ADDR_DATA_H)
      begin
        r_d.rdata = {6'h00, r_q.data[9:8]};
      end
      else if (bus.addr == acs_pkg::ACS_ADDR_IMASK)
      begin
        r_d.rdata = {7'h00, r_q.imask};
      end
      else if (bus.addr == acs_pkg::ACS_ADDR_ISTAT)
      begin
        r_d.rdata = {7'h00, r_q.istat};
      end
      else
      begin
        r_d.rdata = 8'h00;
      end
    end
    else
    begin
      r_d.rdata = 8'h00;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r_q <= '0;
      r_q.ctrl <= acs_pkg::ACS_CTRL_RESET;
      r_q.mux <= acs_pkg::ACS_MUX_RESET;
      r_q.state <= acs_pkg::ACS_IDLE;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign rdata = r_q.rdata;
  assign core.sample_hold = r_q.hold;
  assign core.convert_active = (r_q.state == acs_pkg::ACS_CONV);
  assign core.extended = (r_q.cyc_len == acs_pkg::ACS_EXTENDED_CYCLES);
  assign core.channel_gain = r_q.act_mux;
  assign core.reference = r_q.last_ref;
  assign core.differential = r_q.act_mux[2];
  assign core.gain_20x = r_q.act_mux[2] & r_q.act_mux[0];
  // both sticky flags gated: ctrl flag by irq enable, status bit by mask
  assign irq = (r_q.ctrl[acs_pkg::ACS_BIT_IF] & r_q.ctrl[acs_pkg::ACS_BIT_IE])
             | (r_q.istat[0] & r_q.imask[0]);
endmodule : acs_sequencer

/* File: hw/acs_pkg.sv */
// constants, registers and carrier types for the adc conversion sequencer
// Overview of operation
// - prescaler runs while converter_enable is set, held reset while it is low
// - setting start_conversion begins conversion at next rising adc clock edge
// - differential channel: start only on every second adc edge since enable
// - normal conversion lasts exactly 13 adc clock cycles
// - first conversion after enable, reference change or differential select lasts 25
// - later conversions on same differential channel are normal length
// - sample-and-hold at 1.5 cycles normal, 13.5 cycles extended
// - on completion store result and set conversion_complete_flag
// - single mode: start_conversion clears as result stored and flag set
// - free-running: restart at once after completion, start bit stays set
// - writing zero to start_conversion has no effect
// - clearing enable (bit 7) turns converter off and aborts conversion
// - free_running_select (bit 5) sets continuous conversion, clear ends it
// - channel_gain_select change mid-conversion waits until completion
// - select codes: 0-3 single inputs, 4-5 in2-in2, 6-7 in2-in3, gain 1x/20x
// - reserved bits 4..3 of channel select read zero
// - result is 10-bit unsigned, zero is ground
package acs_pkg;
  localparam logic [3:0] ACS_ADDR_CTRL   = 4'h6;
  localparam logic [3:0] ACS_ADDR_MUX    = 4'h7;
  localparam logic [3:0] ACS_ADDR_DATA_L = 4'h4;
  localparam logic [3:0] ACS_ADDR_DATA_H = 4'h5;
  localparam logic [3:0] ACS_ADDR_IMASK  = 4'h8;
  localparam logic [3:0] ACS_ADDR_ISTAT  = 4'h9;
  localparam int ACS_BIT_EN   = 7;
  localparam int ACS_BIT_SC   = 6;
  localparam int ACS_BIT_FR   = 5;
  localparam int ACS_BIT_IF   = 4;
  localparam int ACS_BIT_IE   = 3;
  localparam int ACS_BIT_DIFF = 2;
  localparam logic [7:0] ACS_CTRL_RESET = 8'h00;
  localparam logic [7:0] ACS_MUX_RESET  = 8'h00;
  localparam logic [4:0] ACS_NORMAL_CYCLES   = 5'h0d;
  localparam logic [4:0] ACS_EXTENDED_CYCLES = 5'h19;
  // hold happens in the low half of cycle index 1 or 13 (1.5 / 13.5)
  localparam logic [4:0] ACS_HOLD_NORMAL     = 5'h01;
  localparam logic [4:0] ACS_HOLD_EXTENDED   = 5'h0d;

  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_WAIT,
    ACS_CONV
  } acs_state_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acs_bus_type;

  typedef struct packed {
    logic       sample_hold;
    logic       convert_active;
    logic       extended;
    logic [2:0] channel_gain;
    logic [1:0] reference;
    logic       differential;
    logic       gain_20x;
  } acs_core_type;

  typedef struct packed {
    acs_state_type state;
    logic [7:0]    ctrl;
    logic [7:0]    mux;
    logic [9:0]    data;
    logic [7:0]    rdata;
    logic [6:0]    pre_cnt;
    logic          adc_clk;
    logic          edge_par;
    logic [4:0]    cyc;
    logic [4:0]    cyc_len;
    logic          ext_pend;
    logic [2:0]    act_mux;
    logic [1:0]    last_ref;
    logic          last_diff;
    logic          hold;
    logic [0:0]    imask;
    logic [0:0]    istat;
  } acs_reg_type;
endpackage : acs_pkg

/* File: tb/acs_sequencer_properties.sv */
// port assertions for the conversion sequencer
module acs_sequencer_checker (
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  input wire acs_pkg::acs_bus_type  bus,
  input wire logic [7:0]            rdata,
  input wire logic [9:0]            core_result,
  input wire acs_pkg::acs_core_type core,
  input wire logic                  irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  logic ctl_wr;
  logic mux_wr;
  assign ctl_wr = bus.wr && bus.addr == acs_pkg::ACS_ADDR_CTRL;
  assign mux_wr = bus.wr && bus.addr == acs_pkg::ACS_ADDR_MUX;
  chk_mux_reserved:
    assert property ($past(bus.rd) && $past(bus.addr) == acs_pkg::ACS_ADDR_MUX |-> !rdata[4:3])
    else $error("reserved bits set");
  chk_hold_inside:
    assert property (core.sample_hold |-> core.convert_active) else $error("hold when idle");
  chk_hold_single:
    assert property (core.sample_hold |=> !core.sample_hold) else $error("hold too long");
  chk_diff_decode:
    assert property (core.differential == core.channel_gain[2]) else $error("diff decode");
  chk_gain_decode:
    assert property (core.gain_20x == (core.channel_gain[2] & core.channel_gain[0]))
    else $error("gain decode");
  chk_chan_frozen:
    assert property (core.convert_active && mux_wr |=> $stable(core.channel_gain)
                     && $stable(core.reference)) else $error("channel moved");
  chk_abort_stop:
    assert property (ctl_wr && !bus.wdata[7] |-> ##2 !core.convert_active [*3])
    else $error("abort ignored");
  chk_zero_start:
    assert property (core.convert_active && ctl_wr && bus.wdata[7:6] == 2'h2
                     |=> core.convert_active) else $error("zero start stopped");
  chk_start_edge:
    assert property (ctl_wr && bus.wdata[7:6] == 2'h3 && bus.wdata[2:1] == 2'h0
                     && !core.convert_active |-> ##[1:8] core.convert_active)
    else $error("no start");
endmodule : acs_sequencer_checker

/* File: tb/acs_core_model.sv */
// behavioural analog core behind the sequencer
module acs_core_model (
  input wire logic                  ref_clk,
  input wire acs_pkg::acs_core_type core,
  input wire logic [9:0]            level,
  output logic [9:0]                result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held_q = 10'h000;
  logic [9:0] noise_q = 10'h2a5;
  always @(posedge ref_clk)
  begin
    noise_q <= noise_q + 10'h16b;
    if (core.sample_hold)
      held_q <= level ^ {7'h00, core.channel_gain};
  end
  // idle line carries noise so a stale result cannot pass
  assign result = core.convert_active ? held_q : noise_q;
endmodule : acs_core_model

/* File: tb/tb_acs_sequencer.sv */
// self-checking bench for the conversion sequencer
module tb_acs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk = 1'b0;
  logic                  sys_rst = 1'b1;
  acs_pkg::acs_bus_type  bus = '0;
  logic [7:0]            rdata;
  logic [9:0]            core_result;
  logic [9:0]            level = 10'h000;
  acs_pkg::acs_core_type core;
  logic                  irq;
  logic                  rd_seen = 1'b0;
  logic [7:0]            exp_q[$];
  int                    fails = 0;
  int                    n_compared = 0;
  logic [2:0]            prev;
  logic [1:0]            rsel;
  logic [9:0]            val;
  always #5 ref_clk = ~ref_clk;
  acs_sequencer u_acs_sequencer (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus),
    .rdata(rdata), .core_result(core_result), .core(core), .irq(irq));
  acs_core_model u_acs_core_model (.ref_clk(ref_clk), .core(core), .level(level),
    .result(core_result));
  task summarize;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task check(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t: want %0h got %0h", $time, e, g);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
  endtask : rd
  // counts adc-domain activity in ref_clk cycles, sampled mid-cycle
  task measure(input logic [15:0] len);
    int n;
    int m;
    n = 0;
    m = 0;
    while ((m == 0 || core.convert_active) && n < 300)
    begin
      @(negedge ref_clk);
      n++;
      m += core.convert_active;
    end
    if (n == 300)
    begin
      fails++;
      summarize();
    end
    else
    begin
      check(len, 16'(m));
      check({15'h0, len == 16'd50}, {15'h0, core.extended});
    end
  endtask : measure
  task irq_is(input logic e);
    repeat (2) @(negedge ref_clk);
    check({15'h0, e}, {15'h0, irq});
  endtask : irq_is
  // read data stand one cycle only, so the watcher samples right then
  always @(posedge ref_clk)
  begin
    if (rd_seen)
      check({8'h00, exp_q.pop_front()}, {8'h00, rdata});
    rd_seen <= bus.rd;
  end
  initial
  begin
    void'($urandom(32'h71e7611e));
    rsel = 2'($urandom);
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(acs_pkg::ACS_ADDR_CTRL, 8'h00);
    rd(4'hf, 8'h00);
    prev = 3'h0;
    for (int c = 0; c < 8; c++)
    begin
      val = 10'($urandom);
      level <= val;
      val ^= 10'(c);
      wr(acs_pkg::ACS_ADDR_MUX, {rsel, 3'h3, 3'(c)});
      rd(acs_pkg::ACS_ADDR_MUX, {rsel, 3'h0, 3'(c)});
      wr(acs_pkg::ACS_ADDR_CTRL, 8'hd0);
      fork
        measure((c == 0 || (c > 3 && !prev[2])) ? 16'd50 : 16'd26);
        begin
          repeat (8) @(posedge ref_clk);
          wr(acs_pkg::ACS_ADDR_CTRL, 8'h80);
          wr(acs_pkg::ACS_ADDR_MUX, {rsel, 6'h00});
        end
      join
      check({13'h0, 3'(c)}, {13'h0, core.channel_gain});
      check({14'h0, rsel}, {14'h0, core.reference});
      rd(acs_pkg::ACS_ADDR_CTRL, 8'h90);
      rd(acs_pkg::ACS_ADDR_DATA_L, val[7:0]);
      rd(acs_pkg::ACS_ADDR_DATA_H, {6'h00, val[9:8]});
      prev = 3'(c);
    end
    wr(acs_pkg::ACS_ADDR_CTRL, 8'h88);
    irq_is(1'b1);
    wr(acs_pkg::ACS_ADDR_CTRL, 8'h98);
    irq_is(1'b0);
    wr(acs_pkg::ACS_ADDR_IMASK, 8'h01);
    irq_is(1'b1);
    rd(acs_pkg::ACS_ADDR_IMASK, 8'h01);
    wr(acs_pkg::ACS_ADDR_ISTAT, 8'h01);
    irq_is(1'b0);
    val = 10'($urandom);
    level <= val;
    wr(acs_pkg::ACS_ADDR_CTRL, 8'he0);
    repeat (100) @(posedge ref_clk);
    rd(acs_pkg::ACS_ADDR_CTRL, 8'hf0);
    rd(acs_pkg::ACS_ADDR_DATA_L, val[7:0]);
    wr(acs_pkg::ACS_ADDR_CTRL, 8'h80);
    repeat (60) @(posedge ref_clk);
    rd(acs_pkg::ACS_ADDR_CTRL, 8'h90);
    wr(acs_pkg::ACS_ADDR_CTRL, 8'hc0);
    repeat (10) @(posedge ref_clk);
    wr(acs_pkg::ACS_ADDR_CTRL, 8'h00);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check(16'h0, {15'h0, core.convert_active});
    rd(acs_pkg::ACS_ADDR_CTRL, 8'h10);
    repeat (3) @(posedge ref_clk);
    summarize();
  end
endmodule : tb_acs_sequencer
bind acs_sequencer acs_sequencer_checker u_acs_sequencer_checker (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .core_result(core_result), .core(core),
  .irq(irq));
